//--- include/cirq_pkg.sv
// package: register map, field positions and reset values of the clock irq / bus reset block
package cirq_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  CIRQ_INT_OFS      = 8'h08;
    localparam logic [7:0]  CIRQ_RST_OFS      = 8'h0c;
    localparam logic [7:0]  CIRQ_NMI_OFS      = 8'h00;
    localparam logic [31:0] CIRQ_INT_RESET    = 32'h0000_0000;
    localparam logic [31:0] CIRQ_RST_RESET    = 32'h0000_0000;
    // ------------------------------------------------------------
    // interrupt register fields
    // ------------------------------------------------------------
    localparam int CIRQ_NFLAG        = 8;
    localparam int CIRQ_CLR_LSB      = 16;
    localparam int CIRQ_EN_LSB       = 8;
    localparam int CIRQ_NEN          = 5;
    localparam int CIRQ_NMI_EN_BIT   = 0;
    // flag positions, also index into clear strobes
    localparam int CIRQ_F_FXTAL_STUCK = 7;
    localparam int CIRQ_F_PLL_STUCK   = 6;
    localparam int CIRQ_F_SXTAL_STUCK = 5;
    localparam int CIRQ_F_PLL_STB     = 4;
    localparam int CIRQ_F_FXTAL_STB   = 3;
    localparam int CIRQ_F_FRC_STB     = 2;
    localparam int CIRQ_F_SXTAL_STB   = 1;
    localparam int CIRQ_F_SRC_STB     = 0;
    // enable positions relative to CIRQ_EN_LSB (bits 12..8)
    localparam int CIRQ_E_PLL_STB     = 4;
    localparam int CIRQ_E_FXTAL_STB   = 3;
    localparam int CIRQ_E_FRC_STB     = 2;
    localparam int CIRQ_E_SXTAL_STB   = 1;
    localparam int CIRQ_E_SRC_STB     = 0;
    // ------------------------------------------------------------
    // reset register fields
    // ------------------------------------------------------------
    localparam logic [31:0] CIRQ_RST_MASK = 32'hc030_7e03;
endpackage : cirq_pkg

//--- include/cirq_bus_if.sv
// interface: register port between bus decode and flag logic
`timescale 1ns/1ps
interface cirq_bus_if;
    logic        int_wr;
    logic [31:0] wdata;
    logic [7:0]  flags;
    logic [4:0]  enables;
    modport regs (output int_wr, output wdata, input flags, input enables);
    modport flag (input int_wr, input wdata, output flags, output enables);
endinterface : cirq_bus_if

//--- logic/cirq_flags.sv
// flag and enable bits of the clock interrupt register
`timescale 1ns/1ps
module cirq_flags
    import cirq_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       nrst,
    cirq_bus_if.flag        bus,
    input  wire logic       nmi_set,
    input  wire logic [7:0] hw_event
);
    logic [7:0] flag_q, flag_d;
    logic [4:0] en_q, en_d;
    logic [7:0] set_v, clr_v;

    always_comb begin
        en_d = en_q;
        if (bus.int_wr) begin
            en_d = bus.wdata[CIRQ_EN_LSB +: CIRQ_NEN];
        end
        set_v = hw_event;
        // stabilization flags only set while the enable is on
        set_v[CIRQ_F_PLL_STB]   = hw_event[CIRQ_F_PLL_STB]   & en_q[CIRQ_E_PLL_STB];
        set_v[CIRQ_F_FXTAL_STB] = hw_event[CIRQ_F_FXTAL_STB] & en_q[CIRQ_E_FXTAL_STB];
        set_v[CIRQ_F_FRC_STB]   = hw_event[CIRQ_F_FRC_STB]   & en_q[CIRQ_E_FRC_STB];
        set_v[CIRQ_F_SXTAL_STB] = hw_event[CIRQ_F_SXTAL_STB] & en_q[CIRQ_E_SXTAL_STB];
        set_v[CIRQ_F_SRC_STB]   = hw_event[CIRQ_F_SRC_STB]   & en_q[CIRQ_E_SRC_STB];
        clr_v = bus.int_wr ? bus.wdata[CIRQ_CLR_LSB +: CIRQ_NFLAG] : 8'h00;
        clr_v[CIRQ_F_FXTAL_STUCK] = clr_v[CIRQ_F_FXTAL_STUCK] | nmi_set;
        // set beats clear so a coincident event survives
        flag_d = (flag_q & ~clr_v) | set_v;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flag_q <= 8'h00;
            en_q   <= 5'h00;
        end else begin
            flag_q <= flag_d;
            en_q   <= en_d;
        end
    end

    assign bus.flags   = flag_q;
    assign bus.enables = en_q;

    property p_set_wins;
        @(posedge clk) disable iff (!nrst)
        hw_event[CIRQ_F_PLL_STUCK] |=> flag_q[CIRQ_F_PLL_STUCK];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost");

    property p_gate;
        @(posedge clk) disable iff (!nrst)
        (!en_q[CIRQ_E_PLL_STB] && !flag_q[CIRQ_F_PLL_STB]) |=> !flag_q[CIRQ_F_PLL_STB];
    endproperty
    a_gate: assert property (p_gate) else $error("pll stable flag set while disabled");

    property p_clear;
        @(posedge clk) disable iff (!nrst)
        (bus.int_wr && bus.wdata[CIRQ_CLR_LSB + CIRQ_F_SXTAL_STUCK]
            && !hw_event[CIRQ_F_SXTAL_STUCK]) |=> !flag_q[CIRQ_F_SXTAL_STUCK];
    endproperty
    a_clear: assert property (p_clear) else $error("slow xtal stuck flag not cleared");

    property p_nmi_clr;
        @(posedge clk) disable iff (!nrst)
        (nmi_set && !hw_event[CIRQ_F_FXTAL_STUCK]) |=> !flag_q[CIRQ_F_FXTAL_STUCK];
    endproperty
    a_nmi_clr: assert property (p_nmi_clr) else $error("nmi enable did not clear flag");

    property p_sticky;
        @(posedge clk) disable iff (!nrst)
        (flag_q[CIRQ_F_FXTAL_STUCK] && !nmi_set
            && !(bus.int_wr && bus.wdata[CIRQ_CLR_LSB + CIRQ_F_FXTAL_STUCK]))
            |=> flag_q[CIRQ_F_FXTAL_STUCK];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without clear");
endmodule : cirq_flags

//--- logic/cirq_rst_reg.sv
// peripheral bus reset register with reserved bits held at zero
`timescale 1ns/1ps
module cirq_rst_reg
    import cirq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        wr,
    input  wire logic [31:0] wdata,
    output logic      [31:0] value
);
    logic [31:0] rst_q, rst_d;

    always_comb begin
        rst_d = rst_q;
        // reserved fields kept at zero whatever software writes
        if (wr) begin
            rst_d = wdata & CIRQ_RST_MASK;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_q <= CIRQ_RST_RESET;
        end else begin
            rst_q <= rst_d;
        end
    end

    assign value = rst_q;

    property p_rsvd;
        @(posedge clk) disable iff (!nrst)
        (rst_q & ~CIRQ_RST_MASK) == 32'h0000_0000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved reset bit set");

    property p_write;
        @(posedge clk) disable iff (!nrst)
        wr |=> rst_q == ($past(wdata) & CIRQ_RST_MASK);
    endproperty
    a_write: assert property (p_write) else $error("reset register write lost");
endmodule : cirq_rst_reg

//--- logic/cirq_top.sv
// top: register port, clock interrupt flags and peripheral reset lines
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
// Operation
// - bits 12:8 enable five stabilization interrupts
// - fast crystal stops sets stuck flag bit7
// - stuck clear bit clears fast crystal flag
// - clock monitor nmi enable also clears it
// - pll stops sets bit6, clear bit clears
// - slow crystal stops sets bit5, clearable
// - pll stable sets bit4 only if enabled
// - fast crystal stable sets bit3 if enabled
// - fast rc stable sets bit2 if enabled
// - slow crystal stable sets bit1 if enabled
// - slow rc stable sets bit0 if enabled
// - reset register at 0x0c resets zero
// - reset bits read-write; can and comparator
// - bits 21,20,13,11 reset advanced timers
// - bits 10,9 reset the adc blocks
// - bit14 resets usart, bit12 resets spi
// - bits 23:16 write-one flag clears
// - bit0 resets system configuration block
module cirq_top
    import cirq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rdata,
    input  wire logic        fast_xtal_stuck,
    input  wire logic        pll_stuck,
    input  wire logic        slow_xtal_stuck,
    input  wire logic        pll_stable,
    input  wire logic        fast_crystal_osc_stable,
    input  wire logic        fast_internal_rc_stable,
    input  wire logic        slow_crystal_osc_stable,
    input  wire logic        slow_internal_rc_stable,
    output logic             clock_irq,
    output logic             clock_monitor_nmi_en,
    output logic             can_b_reset,
    output logic             can_a_reset,
    output logic             adv_timer_d_reset,
    output logic             adv_timer_c_reset,
    output logic             usart_a_reset,
    output logic             adv_timer_b_reset,
    output logic             spi_a_reset,
    output logic             adv_timer_a_reset,
    output logic             adc_b_reset,
    output logic             adc_a_reset,
    output logic             comparator_reset,
    output logic             sysconfig_reset
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    cirq_bus_if bif ();
    logic [31:0] rst_val;
    logic        rst_wr;
    logic        nmi_q, nmi_d;
    logic [31:0] rdata_q, rdata_d;
    logic        irq_q, irq_d;
    logic [7:0]  hw_event;

    assign bif.int_wr = wr_en && hit(addr, CIRQ_INT_OFS);
    assign bif.wdata  = wdata;
    assign rst_wr     = wr_en && hit(addr, CIRQ_RST_OFS);

    always_comb begin
        hw_event = 8'h00;
        hw_event[CIRQ_F_FXTAL_STUCK] = fast_xtal_stuck;
        hw_event[CIRQ_F_PLL_STUCK]   = pll_stuck;
        hw_event[CIRQ_F_SXTAL_STUCK] = slow_xtal_stuck;
        hw_event[CIRQ_F_PLL_STB]     = pll_stable;
        hw_event[CIRQ_F_FXTAL_STB]   = fast_crystal_osc_stable;
        hw_event[CIRQ_F_FRC_STB]     = fast_internal_rc_stable;
        hw_event[CIRQ_F_SXTAL_STB]   = slow_crystal_osc_stable;
        hw_event[CIRQ_F_SRC_STB]     = slow_internal_rc_stable;
    end

    cirq_flags u_flags (
        .clk      (clk),
        .nrst     (nrst),
        .bus      (bif.flag),
        .nmi_set  (nmi_d & ~nmi_q),
        .hw_event (hw_event)
    );

    cirq_rst_reg u_rst (
        .clk   (clk),
        .nrst  (nrst),
        .wr    (rst_wr),
        .wdata (wdata),
        .value (rst_val)
    );

    // ------------------------------------------------------------
    // nmi enable, read mux and irq
    // ------------------------------------------------------------
    always_comb begin
        nmi_d = nmi_q;
        if (wr_en && hit(addr, CIRQ_NMI_OFS)) begin
            nmi_d = wdata[CIRQ_NMI_EN_BIT];
        end
        rdata_d = 32'h0000_0000;
        if (rd_en) begin
            // unmapped addresses read zero, clear strobes read zero
            case (1'b1)
                hit(addr, CIRQ_INT_OFS): begin
                    rdata_d[CIRQ_EN_LSB +: CIRQ_NEN] = bif.enables;
                    rdata_d[CIRQ_NFLAG-1:0]          = bif.flags;
                end
                hit(addr, CIRQ_RST_OFS): rdata_d = rst_val;
                hit(addr, CIRQ_NMI_OFS): rdata_d[CIRQ_NMI_EN_BIT] = nmi_q;
                default:                 rdata_d = 32'h0000_0000;
            endcase
        end
        irq_d = |bif.flags;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            nmi_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
            irq_q   <= 1'b0;
        end else begin
            nmi_q   <= nmi_d;
            rdata_q <= rdata_d;
            irq_q   <= irq_d;
        end
    end

    assign rdata                = rdata_q;
    assign clock_irq            = irq_q;
    assign clock_monitor_nmi_en = nmi_q;
    assign can_b_reset          = rst_val[31];
    assign can_a_reset          = rst_val[30];
    assign adv_timer_d_reset    = rst_val[21];
    assign adv_timer_c_reset    = rst_val[20];
    assign usart_a_reset        = rst_val[14];
    assign adv_timer_b_reset    = rst_val[13];
    assign spi_a_reset          = rst_val[12];
    assign adv_timer_a_reset    = rst_val[11];
    assign adc_b_reset          = rst_val[10];
    assign adc_a_reset          = rst_val[9];
    assign comparator_reset     = rst_val[1];
    assign sysconfig_reset      = rst_val[0];

    property p_irq;
        @(posedge clk) disable iff (!nrst)
        (|bif.flags) |=> clock_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing with flag set");

    property p_stuck_set;
        @(posedge clk) disable iff (!nrst)
        fast_xtal_stuck |=> ##1 clock_irq;
    endproperty
    a_stuck_set: assert property (p_stuck_set) else $error("stuck event gave no irq");

    property p_can;
        @(posedge clk) disable iff (!nrst)
        (rst_wr && wdata[31]) |=> can_b_reset;
    endproperty
    a_can: assert property (p_can) else $error("can reset not held");

    property p_readback;
        @(posedge clk) disable iff (!nrst)
        (rd_en && hit(addr, CIRQ_RST_OFS)) |=> rdata == $past(rst_val);
    endproperty
    a_readback: assert property (p_readback) else $error("reset register readback wrong");

    // ------------------------------------------------------------
    // per-field checks on flags, enables and reset lines
    // ------------------------------------------------------------
    property p_en_write;
        @(posedge clk) disable iff (!nrst)
        bif.int_wr |=> bif.enables == $past(wdata[CIRQ_EN_LSB +: CIRQ_NEN]);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable bits not written");

    property p_int_read;
        @(posedge clk) disable iff (!nrst)
        (rd_en && hit(addr, CIRQ_INT_OFS))
            |=> rdata == {19'h0, $past(bif.enables), $past(bif.flags)};
    endproperty
    a_int_read: assert property (p_int_read) else $error("interrupt readback wrong");

    property p_fx_stuck_set;
        @(posedge clk) disable iff (!nrst)
        fast_xtal_stuck |=> bif.flags[CIRQ_F_FXTAL_STUCK];
    endproperty
    a_fx_stuck_set: assert property (p_fx_stuck_set) else $error("fast stuck not set");

    property p_fx_stuck_clr;
        @(posedge clk) disable iff (!nrst)
        (bif.int_wr && wdata[CIRQ_CLR_LSB + CIRQ_F_FXTAL_STUCK] && !fast_xtal_stuck)
            |=> !bif.flags[CIRQ_F_FXTAL_STUCK];
    endproperty
    a_fx_stuck_clr: assert property (p_fx_stuck_clr) else $error("fast stuck not cleared");

    property p_pll_stuck_clr;
        @(posedge clk) disable iff (!nrst)
        (bif.int_wr && wdata[CIRQ_CLR_LSB + CIRQ_F_PLL_STUCK] && !pll_stuck)
            |=> !bif.flags[CIRQ_F_PLL_STUCK];
    endproperty
    a_pll_stuck_clr: assert property (p_pll_stuck_clr) else $error("pll stuck not cleared");

    property p_sx_stuck_set;
        @(posedge clk) disable iff (!nrst)
        slow_xtal_stuck |=> bif.flags[CIRQ_F_SXTAL_STUCK];
    endproperty
    a_sx_stuck_set: assert property (p_sx_stuck_set) else $error("slow stuck not set");

    property p_pll_stb_set;
        @(posedge clk) disable iff (!nrst)
        (pll_stable && bif.enables[CIRQ_E_PLL_STB]) |=> bif.flags[CIRQ_F_PLL_STB];
    endproperty
    a_pll_stb_set: assert property (p_pll_stb_set) else $error("pll stable not set");

    property p_fx_stb_set;
        @(posedge clk) disable iff (!nrst)
        (fast_crystal_osc_stable && bif.enables[CIRQ_E_FXTAL_STB]) |=> bif.flags[CIRQ_F_FXTAL_STB];
    endproperty
    a_fx_stb_set: assert property (p_fx_stb_set) else $error("fast xtal stable not set");

    property p_fx_stb_gate;
        @(posedge clk) disable iff (!nrst)
        (!bif.enables[CIRQ_E_FXTAL_STB] && !bif.flags[CIRQ_F_FXTAL_STB])
            |=> !bif.flags[CIRQ_F_FXTAL_STB];
    endproperty
    a_fx_stb_gate: assert property (p_fx_stb_gate) else $error("fast xtal flag ungated");

    property p_frc_set;
        @(posedge clk) disable iff (!nrst)
        (fast_internal_rc_stable && bif.enables[CIRQ_E_FRC_STB]) |=> bif.flags[CIRQ_F_FRC_STB];
    endproperty
    a_frc_set: assert property (p_frc_set) else $error("fast rc stable not set");

    property p_frc_gate;
        @(posedge clk) disable iff (!nrst)
        (!bif.enables[CIRQ_E_FRC_STB] && !bif.flags[CIRQ_F_FRC_STB])
            |=> !bif.flags[CIRQ_F_FRC_STB];
    endproperty
    a_frc_gate: assert property (p_frc_gate) else $error("fast rc flag ungated");

    property p_sx_stb_set;
        @(posedge clk) disable iff (!nrst)
        (slow_crystal_osc_stable && bif.enables[CIRQ_E_SXTAL_STB]) |=> bif.flags[CIRQ_F_SXTAL_STB];
    endproperty
    a_sx_stb_set: assert property (p_sx_stb_set) else $error("slow xtal stable not set");

    property p_sx_stb_gate;
        @(posedge clk) disable iff (!nrst)
        (!bif.enables[CIRQ_E_SXTAL_STB] && !bif.flags[CIRQ_F_SXTAL_STB])
            |=> !bif.flags[CIRQ_F_SXTAL_STB];
    endproperty
    a_sx_stb_gate: assert property (p_sx_stb_gate) else $error("slow xtal flag ungated");

    property p_src_set;
        @(posedge clk) disable iff (!nrst)
        (slow_internal_rc_stable && bif.enables[CIRQ_E_SRC_STB]) |=> bif.flags[CIRQ_F_SRC_STB];
    endproperty
    a_src_set: assert property (p_src_set) else $error("slow rc stable not set");

    property p_src_gate;
        @(posedge clk) disable iff (!nrst)
        (!bif.enables[CIRQ_E_SRC_STB] && !bif.flags[CIRQ_F_SRC_STB])
            |=> !bif.flags[CIRQ_F_SRC_STB];
    endproperty
    a_src_gate: assert property (p_src_gate) else $error("slow rc flag ungated");

    property p_timers;
        @(posedge clk) disable iff (!nrst)
        rst_wr |=> {adv_timer_d_reset, adv_timer_c_reset, adv_timer_b_reset, adv_timer_a_reset}
            == {$past(wdata[21]), $past(wdata[20]), $past(wdata[13]), $past(wdata[11])};
    endproperty
    a_timers: assert property (p_timers) else $error("timer reset lines wrong");

    property p_adc;
        @(posedge clk) disable iff (!nrst)
        rst_wr |=> {adc_b_reset, adc_a_reset} == $past(wdata[10:9]);
    endproperty
    a_adc: assert property (p_adc) else $error("adc reset lines wrong");

    property p_usart_spi;
        @(posedge clk) disable iff (!nrst)
        rst_wr |=> {usart_a_reset, spi_a_reset} == {$past(wdata[14]), $past(wdata[12])};
    endproperty
    a_usart_spi: assert property (p_usart_spi) else $error("usart or spi reset wrong");

    property p_cfg_cmp;
        @(posedge clk) disable iff (!nrst)
        rst_wr |=> {comparator_reset, sysconfig_reset} == $past(wdata[1:0]);
    endproperty
    a_cfg_cmp: assert property (p_cfg_cmp) else $error("config or cmp reset wrong");

    property p_rst_hold;
        @(posedge clk) disable iff (!nrst)
        !rst_wr |=> $stable(rst_val);
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("reset register changed");

    property p_stb_clr;
        @(posedge clk) disable iff (!nrst)
        (bif.int_wr && wdata[CIRQ_CLR_LSB + CIRQ_F_PLL_STB]
            && !(pll_stable && bif.enables[CIRQ_E_PLL_STB])) |=> !bif.flags[CIRQ_F_PLL_STB];
    endproperty
    a_stb_clr: assert property (p_stb_clr) else $error("pll stable not cleared");

    property p_irq_low;
        @(posedge clk) disable iff (!nrst)
        !(|bif.flags) |=> !clock_irq;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("irq without flag");

    property p_nmi_out;
        @(posedge clk) disable iff (!nrst)
        (wr_en && hit(addr, CIRQ_NMI_OFS))
            |=> clock_monitor_nmi_en == $past(wdata[CIRQ_NMI_EN_BIT]);
    endproperty
    a_nmi_out: assert property (p_nmi_out) else $error("nmi enable not written");
endmodule : cirq_top

//--- verification/clock_irq_and_apb2_reset_tb_top.sv
// testbench: register port, clock flags and peripheral reset lines
`timescale 1ns/1ps
module clock_irq_and_apb2_reset_tb_top
    import cirq_pkg::*;
;
    logic        clk;
    logic        nrst;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rdata;
    logic [4:0]  stb;
    logic [2:0]  stk;
    logic        clock_irq;
    logic        nmi_en;
    logic [11:0] rst_out;
    logic [31:0] exp_q[$];
    logic        rd_seen = 1'b0;
    logic [4:0]  en_v;
    logic [31:0] rv;
    int          num_errors = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          seed = 46;

    cirq_top DUT (
        .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .fast_xtal_stuck(stk[2]), .pll_stuck(stk[1]), .slow_xtal_stuck(stk[0]),
        .pll_stable(stb[4]), .fast_crystal_osc_stable(stb[3]),
        .fast_internal_rc_stable(stb[2]), .slow_crystal_osc_stable(stb[1]),
        .slow_internal_rc_stable(stb[0]),
        .clock_irq(clock_irq), .clock_monitor_nmi_en(nmi_en),
        .can_b_reset(rst_out[11]), .can_a_reset(rst_out[10]),
        .adv_timer_d_reset(rst_out[9]), .adv_timer_c_reset(rst_out[8]),
        .usart_a_reset(rst_out[7]), .adv_timer_b_reset(rst_out[6]),
        .spi_a_reset(rst_out[5]), .adv_timer_a_reset(rst_out[4]),
        .adc_b_reset(rst_out[3]), .adc_a_reset(rst_out[2]),
        .comparator_reset(rst_out[1]), .sysconfig_reset(rst_out[0])
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lines(input logic [31:0] v);
        return {20'h0, v[31:30], v[21:20], v[14:9], v[1:0]};
    endfunction : lines

    function automatic logic [31:0] iw(input logic [4:0] e, input logic [7:0] f);
        return {19'h0, e, f};
    endfunction : iw

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic tally_and_finish();
        // a queued read that never got its data is a lost answer
        if (exp_q.size() != 0) begin
            num_errors++;
            $display("CHECK FAILED rdata_queue expected 0 seen %0d", exp_q.size());
        end
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    // expectation is queued by the driver, compared by the monitor
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd_en <= 1'b0;
    endtask : rd

    // one-cycle hardware event
    task automatic ev(input logic [4:0] s, input logic [2:0] k);
        @(posedge clk);
        stb <= s;
        stk <= k;
        @(posedge clk);
        stb <= 5'h00;
        stk <= 3'h0;
    endtask : ev

    // ------------------------------------------------------------
    // clock, monitor, timeout
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // rdata stands only in the cycle after rd_en
    always @(posedge clk) begin
        if (rd_seen && exp_q.size() > 0) begin
            chk("rdata", exp_q.pop_front(), rdata);
        end
        rd_seen <= rd_en;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        nrst = 1'b0; addr = 8'h00; wdata = 32'h0; wr_en = 1'b0; rd_en = 1'b0;
        stb = 5'h00; stk = 3'h0; en_v = 5'h00; rv = 32'h0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        rd(CIRQ_RST_OFS, 32'h0000_0000);
        rd(CIRQ_INT_OFS, 32'h0000_0000);
        @(negedge clk);
        chk("reset_lines", 32'h0, {20'h0, rst_out});
        // reserved fields always written as zero by software
        for (int i = 0; i < 8; i++) begin
            rv = (i == 0) ? CIRQ_RST_MASK : ($random(seed) & CIRQ_RST_MASK);
            wr(CIRQ_RST_OFS, rv);
            @(negedge clk);
            chk("reset_lines", lines(rv), {20'h0, rst_out});
            rd(CIRQ_RST_OFS, rv);
        end
        wr(8'h04, 32'hffff_ffff);
        rd(8'h04, 32'h0);
        rd(CIRQ_RST_OFS, rv);
        // each stable source: disabled, then enabled, then cleared
        for (int i = 0; i < 5; i++) begin
            en_v = 5'h1f & ~(5'h01 << i);
            wr(CIRQ_INT_OFS, iw(en_v, 8'h00));
            ev(5'h01 << i, 3'h0);
            rd(CIRQ_INT_OFS, iw(en_v, 8'h00));
            en_v = 5'h1f;
            wr(CIRQ_INT_OFS, iw(en_v, 8'h00));
            ev(5'h01 << i, 3'h0);
            rd(CIRQ_INT_OFS, iw(en_v, 8'h01 << i));
            @(negedge clk);
            chk("clock_irq", 32'h1, {31'h0, clock_irq});
            wr(CIRQ_INT_OFS, iw(en_v, 8'h00) | (32'h1 << (16 + i)));
            rd(CIRQ_INT_OFS, iw(en_v, 8'h00));
            @(negedge clk);
            chk("clock_irq", 32'h0, {31'h0, clock_irq});
        end
        // stuck monitors: flags 5..7, clears 21..23
        for (int i = 0; i < 3; i++) begin
            ev(5'h00, 3'h1 << i);
            rd(CIRQ_INT_OFS, iw(en_v, 8'h20 << i));
            wr(CIRQ_INT_OFS, iw(en_v, 8'h00) | (32'h1 << (21 + i)));
            rd(CIRQ_INT_OFS, iw(en_v, 8'h00));
        end
        // nmi enable rising also clears the fast crystal stuck flag
        ev(5'h00, 3'h4);
        wr(CIRQ_NMI_OFS, 32'h1);
        rd(CIRQ_INT_OFS, iw(en_v, 8'h00));
        @(negedge clk);
        chk("nmi_en", 32'h1, {31'h0, nmi_en});
        // event during the clear write must survive
        @(posedge clk);
        stk <= 3'h2;
        wr(CIRQ_INT_OFS, iw(en_v, 8'h00) | 32'h0040_0000);
        stk <= 3'h0;
        rd(CIRQ_INT_OFS, iw(en_v, 8'h40));
        repeat (3) @(posedge clk);
        tally_and_finish();
    end
endmodule : clock_irq_and_apb2_reset_tb_top
